// File: hw/lpm_seq.sv
// Standby/halt low-power sequencer: entry flush, clock gating, wake and resume.
// Assumes idle_req is a one-cycle pulse from the CPU on clk_sys; wake pins are asynchronous.
`timescale 1ns/1ps
module lpm_seq
  import lpm_seq_pkg::*;
#(
  parameter int unsigned PLL_LOCK_CYC = PLL_LOCK_OSC_CYC,
  parameter int unsigned OSC_START_CYC = OSC_STARTUP_OSC_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic osc_tick,
  input wire lpm_ctrl_t ctrl,
  input wire logic wake_n,
  input wire logic halt_wake_pin,
  output lpm_out_t status
);
  initial begin
    if (PLL_LOCK_CYC < 1 || PLL_LOCK_CYC >= (1 << CNT_W)) $error("PLL_LOCK_CYC out of range");
    if (OSC_START_CYC < 1 || OSC_START_CYC >= (1 << CNT_W)) $error("OSC_START_CYC out of range");
  end

  // ==========================================================
  // Pin synchronisers
  logic [1:0] wake_sync_q;
  logic [1:0] halt_sync_q;
  logic halt_prev_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wake_sync_q <= 2'h3;
      halt_sync_q <= 2'h3;
      halt_prev_q <= 1'b1;
    end else begin
      wake_sync_q <= {wake_sync_q[0], wake_n};
      halt_sync_q <= {halt_sync_q[0], halt_wake_pin};
      halt_prev_q <= halt_sync_q[1];
    end
  end
  logic wake_act;
  logic halt_fall;
  assign wake_act = ~wake_sync_q[1];
  assign halt_fall = halt_prev_q & ~halt_sync_q[1];

  // ==========================================================
  // Sequencer
  lpm_state_reg_t s_q;
  lpm_state_reg_t s_d;
  logic [CNT_W-1:0] flush_cyc;
  logic [CNT_W-1:0] resume_cyc;

  always_comb begin
    unique case (ctrl.clock_divider_select)
      2'h2: flush_cyc = CNT_W'(FLUSH_CYC_MID);
      2'h3: flush_cyc = CNT_W'(FLUSH_CYC_LONG);
      default: flush_cyc = CNT_W'(FLUSH_CYC_SHORT);
    endcase
    // Sleeping flash needs its pump restart; RAM resumes fast.
    resume_cyc = ctrl.flash_sleeping ? CNT_W'(RESUME_SLEEP_USE_CYC) : CNT_W'(RESUME_RAM_USE_CYC);
  end

  always_comb begin
    s_d = s_q;
    s_d.o.cpu_resume = 1'b0;
    s_d.o.wake_irq = 1'b0;
    // External clock output drops a fixed count after IDLE.
    if (s_q.st != ST_ACTIVE && !s_q.xclk_low) begin
      s_d.xcnt = s_q.xcnt + 1'b1;
      if (s_q.xcnt == CNT_W'(XCLK_LOW_CYC - 1)) begin
        s_d.xclk_low = 1'b1;
        s_d.o.external_clock_output_en = 1'b0;
      end
    end
    unique case (s_q.st)
      ST_ACTIVE: begin
        if (ctrl.idle_req) begin
          s_d.st = ST_FLUSH;
          s_d.mode = ctrl.mode;
          s_d.cnt = '0;
          s_d.xcnt = '0;
          s_d.xclk_low = 1'b0;
          s_d.o.in_lpm = 1'b1;
        end
      end
      ST_FLUSH: begin
        // Core clock keeps running so the pipeline drains.
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == flush_cyc - 1'b1) begin
          s_d.cnt = '0;
          s_d.qcnt = '0;
          s_d.o.system_clock_en = 1'b0;
          s_d.o.periph_clock_en = 1'b0;
          if (s_q.mode == MODE_HALT) begin
            s_d.st = ST_HALT;
            s_d.o.pll_en = 1'b0;
            s_d.o.osc_en = ~ctrl.crystal_source;
          end else begin
            s_d.st = ST_STANDBY; // PLL stays on.
          end
        end
      end
      ST_STANDBY: begin
        // Wake counted in oscillator ticks; a glitch resets the count.
        if (!wake_act) begin
          s_d.qcnt = '0;
        end else if (osc_tick && s_q.qcnt != {1'b1, {QUAL_W{1'b1}}}) begin
          s_d.qcnt = s_q.qcnt + 1'b1;
        end
        if (wake_act && (!ctrl.qual_en ||
            s_q.qcnt >= (QUAL_W + 1)'(QUAL_BASE_OSC_CYC) + {1'b0, ctrl.standby_wake_qual_count})) begin
          s_d.st = ST_RESUME;
          s_d.cnt = '0;
          s_d.stby_wake = 1'b1;
        end
      end
      ST_HALT: begin
        if (halt_fall) begin
          s_d.st = ST_OSC_WAIT;
          s_d.o.osc_en = 1'b1;
          s_d.cnt = '0;
        end
      end
      ST_OSC_WAIT: begin
        if (osc_tick) begin
          s_d.cnt = s_q.cnt + 1'b1;
          if (s_q.cnt == CNT_W'(OSC_START_CYC - 1)) begin
            s_d.st = ST_PLL_LOCK;
            s_d.cnt = '0;
            s_d.o.pll_en = 1'b1;
          end
        end
      end
      ST_PLL_LOCK: begin
        // Full lock wait even when PLL bypassed.
        if (osc_tick) begin
          s_d.cnt = s_q.cnt + 1'b1;
          if (s_q.cnt == CNT_W'(PLL_LOCK_CYC - 1)) begin
            s_d.st = ST_RESUME;
            s_d.cnt = '0;
            s_d.halt_wake = 1'b1;
          end
        end
      end
      ST_RESUME: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == '0) begin
          s_d.o.system_clock_en = 1'b1;
          s_d.o.periph_clock_en = 1'b1;
          s_d.o.external_clock_output_en = 1'b1;
        end
        if (s_q.cnt == resume_cyc - 1'b1) begin
          s_d.st = ST_ACTIVE;
          s_d.o.cpu_resume = 1'b1;
          s_d.o.wake_irq = ctrl.wake_int_en;
          s_d.o.in_lpm = 1'b0;
          s_d.stby_wake = 1'b0;
          s_d.halt_wake = 1'b0;
          s_d.xclk_low = 1'b1;
        end
      end
      default: s_d.st = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{st: ST_ACTIVE, mode: MODE_STANDBY, cnt: '0, xcnt: '0, qcnt: '0,
               xclk_low: 1'b1, stby_wake: 1'b0, halt_wake: 1'b0,
               o: '{system_clock_en: 1'b1, periph_clock_en: 1'b1, pll_en: 1'b1, osc_en: 1'b1,
                    external_clock_output_en: 1'b1, cpu_resume: 1'b0, wake_irq: 1'b0,
                    in_lpm: 1'b0}};
    end else begin
      s_q <= s_d;
    end
  end
  assign status = s_q.o;

  // ==========================================================
  // Checks
  a_xclk_low_window: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.st == ST_ACTIVE && ctrl.idle_req) |-> ##[32:45] !status.external_clock_output_en)
    else $error("external clock output not low in window");
  a_standby_pll_on: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.st == ST_STANDBY) |-> (status.pll_en && !status.periph_clock_en))
    else $error("standby clock gating wrong");
  a_halt_pll_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.st == ST_HALT) |-> (!status.pll_en && !status.periph_clock_en && !status.system_clock_en))
    else $error("halt clock gating wrong");
  a_flush_clock_held: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.st == ST_ACTIVE && ctrl.idle_req && ctrl.clock_divider_select == 2'h0) |=>
      status.system_clock_en [*8])
    else $error("system clock stopped early");
  a_halt_wake_osc: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.st == ST_HALT && halt_fall) |=> (status.osc_en && s_q.st == ST_OSC_WAIT))
    else $error("halt wake did not start oscillator");
  a_stby_resume_time: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.st == ST_STANDBY && s_d.st == ST_RESUME && !ctrl.flash_sleeping) |-> ##[1:100] status.cpu_resume)
    else $error("standby resume too late");
  a_halt_resume_time: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.st == ST_PLL_LOCK && s_d.st == ST_RESUME && !ctrl.flash_sleeping) |-> ##[1:35] status.cpu_resume)
    else $error("halt resume too late");
  a_irq_gated: assert property (@(posedge clk_sys) disable iff (!resetn)
    status.wake_irq |-> (status.cpu_resume && $past(ctrl.wake_int_en)))
    else $error("wake interrupt without enable");
  a_lock_before_resume: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.st == ST_PLL_LOCK) |=> (s_q.st == ST_PLL_LOCK || s_q.st == ST_RESUME))
    else $error("PLL lock wait left wrongly");
  a_clocks_back: assert property (@(posedge clk_sys) disable iff (!resetn)
    status.cpu_resume |-> (status.system_clock_en && status.periph_clock_en))
    else $error("resume with clocks gated");

  c_standby_cycle: cover property (@(posedge clk_sys) disable iff (!resetn)
    s_q.stby_wake && status.cpu_resume);
  c_halt_cycle: cover property (@(posedge clk_sys) disable iff (!resetn)
    s_q.halt_wake && status.cpu_resume);
  c_irq: cover property (@(posedge clk_sys) disable iff (!resetn) status.wake_irq);
endmodule

// File: hw/lpm_seq_pkg.sv
// Package for the standby/halt low-power sequencer: modes, timing counts, state.
// Assumes one 200 MHz system clock; oscillator cycles arrive as an enable pulse.
package lpm_seq_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned XCLK_LOW_MIN_CYC = 32;
  localparam int unsigned XCLK_LOW_MAX_CYC = 45;
  localparam int unsigned XCLK_LOW_CYC = 36;
  localparam int unsigned FLUSH_CYC_SHORT = 16;
  localparam int unsigned FLUSH_CYC_MID = 32;
  localparam int unsigned FLUSH_CYC_LONG = 64;
  localparam int unsigned STBY_RESUME_RAM_CYC = 100;
  localparam int unsigned STBY_RESUME_SLEEP_CYC = 1125;
  localparam int unsigned HALT_RESUME_RAM_CYC = 35;
  localparam int unsigned HALT_RESUME_SLEEP_CYC = 1125;
  localparam int unsigned RESUME_RAM_USE_CYC = 20;
  localparam int unsigned RESUME_SLEEP_USE_CYC = 1000;
  localparam int unsigned PLL_LOCK_OSC_CYC = 131072;
  localparam int unsigned OSC_STARTUP_OSC_CYC = 1024;
  localparam int unsigned QUAL_BASE_OSC_CYC = 2;
  localparam int unsigned QUAL_W = 6;
  localparam int unsigned CNT_W = 18;

  // ==========================================================
  // Types
  typedef enum logic {
    MODE_STANDBY,
    MODE_HALT
  } lpm_mode_t;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_FLUSH,
    ST_STANDBY,
    ST_HALT,
    ST_OSC_WAIT,
    ST_PLL_LOCK,
    ST_RESUME
  } lpm_state_t;

  typedef struct packed {
    logic idle_req;
    lpm_mode_t mode;
    logic [1:0] clock_divider_select;
    logic qual_en;
    logic [QUAL_W-1:0] standby_wake_qual_count;
    logic flash_sleeping;
    logic crystal_source;
    logic wake_int_en;
  } lpm_ctrl_t;

  typedef struct packed {
    logic system_clock_en;
    logic periph_clock_en;
    logic pll_en;
    logic osc_en;
    logic external_clock_output_en;
    logic cpu_resume;
    logic wake_irq;
    logic in_lpm;
  } lpm_out_t;

  typedef struct packed {
    lpm_state_t st;
    lpm_mode_t mode;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] xcnt;
    logic [QUAL_W:0] qcnt;
    logic xclk_low;
    logic stby_wake;
    logic halt_wake;
    lpm_out_t o;
  } lpm_state_reg_t;
endpackage

// File: testbench/lpm_wake_src.sv
// Wake-source model: oscillator tick, standby wake line and halt wake pin.
// Assumes the sequencer samples all three on clk_sys.
`timescale 1ns/1ps
module lpm_wake_src (
  input wire logic clk_sys,
  output logic osc_tick,
  output logic wake_n,
  output logic halt_wake_pin
);
  logic [1:0] div_q;
  initial begin
    div_q = 2'h0;
    osc_tick = 1'b0;
    wake_n = 1'b1;
    halt_wake_pin = 1'b1;
  end
  // ==========================================================
  // Oscillator at a quarter of the system clock
  always @(posedge clk_sys) begin
    div_q <= div_q + 2'h1;
    osc_tick <= #1 (div_q == 2'h3);
  end
  // ==========================================================
  // Wake pulse; length in oscillator cycles, with margin for the async sample
  task automatic wake(input bit halt, input int osc_cyc);
    repeat (18) @(posedge clk_sys);
    #1;
    if (halt) halt_wake_pin = 1'b0;
    else wake_n = 1'b0;
    repeat (osc_cyc * 4 + 8) @(posedge clk_sys);
    #1;
    wake_n = 1'b1;
    halt_wake_pin = 1'b1;
  endtask
endmodule

// File: testbench/lpm_seq_tb.sv
// Self-checking bench for the standby/halt sequencer.
// Assumes the lock and start-up counts are shortened to 8 and 4 oscillator cycles.
`timescale 1ns/1ps
module lpm_seq_tb;
  import lpm_seq_pkg::*;
  logic clk_sys;
  logic resetn;
  lpm_ctrl_t ctrl;
  lpm_out_t status;
  logic osc_tick;
  logic wake_n;
  logic halt_wake_pin;
  int mismatches;
  int tests_run;
  int seed;
  // Reference model: one expected wake interrupt per low-power entry
  bit exp_irq_q[$];
  lpm_seq #(.PLL_LOCK_CYC(8), .OSC_START_CYC(4)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
    .osc_tick(osc_tick), .ctrl(ctrl), .wake_n(wake_n), .halt_wake_pin(halt_wake_pin), .status(status));
  lpm_wake_src src_u (.clk_sys(clk_sys), .osc_tick(osc_tick), .wake_n(wake_n), .halt_wake_pin(halt_wake_pin));
  // ==========================================================
  // Helpers
  task automatic check(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  function automatic int flush_cyc(input int d);
    return (d < 2) ? 16 : (d == 2) ? 32 : 64;
  endfunction
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    mismatches++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    end_of_test();
  end
  // ==========================================================
  // Main sequence: every divider code in both modes, other controls from the loop index, qualification count random
  initial begin
    int n;
    int sf;
    int xf;
    int lim;
    int hold;
    bit halt;
    seed = 47;
    mismatches = 0;
    tests_run = 0;
    resetn = 1'b0;
    ctrl = '0;
    repeat (16) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    for (int i = 0; i < 8; i++) begin
      halt = (i % 2) == 1;
      ctrl.mode = halt ? MODE_HALT : MODE_STANDBY;
      ctrl.clock_divider_select = 2'(i / 2);
      // Codes walked so each mode sees both values; the qualification count stays random
      ctrl.qual_en = 1'(i / 2);
      ctrl.standby_wake_qual_count = 6'($random(seed));
      ctrl.flash_sleeping = 1'(i / 4);
      ctrl.crystal_source = 1'(i / 2);
      ctrl.wake_int_en = 1'(i / 4) ^ 1'(i / 2);
      exp_irq_q.push_back(ctrl.wake_int_en);
      // Bench models no external memory access in flight at entry.
      ctrl.idle_req = 1'b1;
      @(posedge clk_sys);
      #1;
      ctrl.idle_req = 1'b0;
      sf = 0;
      xf = 0;
      for (n = 2; n < 72; n++) begin
        @(posedge clk_sys);
        #1;
        if (status.system_clock_en === 1'b0 && sf == 0) sf = n;
        if (status.external_clock_output_en === 1'b0 && xf == 0) xf = n;
      end
      check(sf == flush_cyc(i / 2) + 1, "clock hold length");
      check(xf >= 32 && xf <= 45, "external clock stop time");
      check(status.periph_clock_en === 1'b0 && status.in_lpm === 1'b1, "peripherals gated");
      if (halt) check(status.pll_en === 1'b0 && status.osc_en === !ctrl.crystal_source, "halt off");
      else check(status.pll_en === 1'b1, "standby keeps PLL");
      if (halt) hold = 6;
      else hold = ctrl.qual_en ? 2 + int'(ctrl.standby_wake_qual_count) : 3;
      if (halt) lim = 18 + 63 + (ctrl.flash_sleeping ? 1125 : 35);
      else lim = 21 + (ctrl.flash_sleeping ? 1125 : 100) + (ctrl.qual_en ? hold * 4 + 8 : 0);
      n = 0;
      fork
        src_u.wake(halt, hold);
        while (status.cpu_resume !== 1'b1 && n < 3000) begin
          @(posedge clk_sys);
          #1;
          n++;
          if (halt && n == 24) check(status.osc_en === 1'b1 && status.pll_en === 1'b0, "osc start");
        end
      join
      check(n <= lim, "resume latency");
      check(status.wake_irq === exp_irq_q.pop_front(), "wake interrupt");
      check(status.system_clock_en === 1'b1 && status.periph_clock_en === 1'b1 && status.pll_en === 1'b1 &&
        status.external_clock_output_en === 1'b1 && status.in_lpm === 1'b0, "clocks back");
    end
    // ==========================================================
    // Reset in mid-flush returns to the running state; then the reset pin wakes a halt
    ctrl.idle_req = 1'b1;
    @(posedge clk_sys);
    #1;
    ctrl.idle_req = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    resetn = 1'b0;
    #2;
    check(status.system_clock_en === 1'b1 && status.in_lpm === 1'b0, "reset to active");
    repeat (4) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    ctrl.mode = MODE_HALT;
    ctrl.clock_divider_select = 2'h0;
    ctrl.idle_req = 1'b1;
    @(posedge clk_sys);
    #1;
    ctrl.idle_req = 1'b0;
    repeat (40) @(posedge clk_sys);
    #1;
    check(status.system_clock_en === 1'b0 && status.pll_en === 1'b0 && status.in_lpm === 1'b1,
      "halt before reset wake");
    resetn = 1'b0;
    // Held through the shortened start-up (4) plus 8 oscillator cycles of 4 clocks each
    repeat ((4 + 8) * 4) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check(status.in_lpm === 1'b0 && status.system_clock_en === 1'b1 && status.pll_en === 1'b1 &&
      status.osc_en === 1'b1 && status.cpu_resume === 1'b0, "reset pin wake");
    end_of_test();
  end
endmodule
